// [flash_sram_select_and_paging_bench.sv]
`timescale 1ns/1ps
module flash_sram_select_and_paging_bench
    import fssp_pkg::*;
;
    localparam int RW = 8;
    logic ref_clk_i, rst_n_i, wr, rd, fetch, sram, rb, per, ld, sec, set;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata_o, page_bits_o, flash_wdata_o;
    logic [3:0]  psel, prot_p, primary_sel_o;
    logic [1:0]  ssel, prot_s, secondary_sel_o;
    logic [4:0]  st_set, st;
    logic [15:0] flash_waddr_o;
    logic sram_en_o, io_sel_o, flash_wr_o, resume_erase_o, reset_flash_o;
    logic abort_erase_o, read_mode_o;
    int n_mismatch = 0;
    int num_checks = 0;

    fssp_mem_ctrl #(.RESET_WAIT(RW)) uut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .program_fetch_strobe_i(fetch),
        .primary_sector_selects_i(psel), .secondary_sector_selects_i(ssel),
        .sram_select_i(sram), .register_block_select_i(rb), .periph_select_i(per),
        .prot_load_i(ld), .prot_primary_i(prot_p), .prot_secondary_i(prot_s),
        .security_set_i(sec), .prog_busy_i(st[4]), .bulk_erase_busy_i(st[3]),
        .sector_erase_busy_i(st[2]), .erase_suspended_i(st[1]), .error_flag_i(st[0]),
        .primary_sel_o(primary_sel_o), .secondary_sel_o(secondary_sel_o),
        .sram_en_o(sram_en_o), .io_sel_o(io_sel_o), .rdata_o(rdata_o),
        .page_bits_o(page_bits_o), .flash_wr_o(flash_wr_o), .flash_wdata_o(flash_wdata_o),
        .flash_waddr_o(flash_waddr_o), .resume_erase_o(resume_erase_o),
        .reset_flash_o(reset_flash_o), .abort_erase_o(abort_erase_o),
        .read_mode_o(read_mode_o));

    fssp_flash_model flash (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .set_i(set), .st_i(st_set),
        .reset_flash_i(reset_flash_o), .abort_erase_i(abort_erase_o),
        .resume_erase_i(resume_erase_o), .st_o(st));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one access cycle, then idle; registered answers are sampled after the next edge
    task automatic acc(input logic w, r, f, input logic [15:0] a, input logic [7:0] d,
                       input logic [3:0] p, input logic [1:0] s, input logic sr, rbs, pe);
        @(posedge ref_clk_i);
        {wr, rd, fetch, addr, wdata, psel, ssel, sram, rb, per} <= {w, r, f, a, d, p, s, sr, rbs, pe};
        @(posedge ref_clk_i);
        {wr, rd, fetch, psel, ssel, sram, rb, per} <= '0;
        #1;
    endtask : acc

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, {8'h00, a}, d, 4'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        acc(1'b0, 1'b1, 1'b0, {8'h00, a}, 8'h00, 4'h0, 2'h0, 1'b0, 1'b1, 1'b0);
        chk({8'h00, rdata_o}, {8'h00, exp}, what);
    endtask : reg_rd

    task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [3:0] p,
                       input logic [1:0] s);
        acc(1'b1, 1'b0, 1'b0, a, d, p, s, 1'b0, 1'b0, 1'b0);
    endtask : cmd

    task automatic status(input logic [4:0] v);
        @(posedge ref_clk_i);
        set <= 1'b1;
        st_set <= v;
        @(posedge ref_clk_i);
        set <= 1'b0;
    endtask : status

    task automatic route(input logic [7:0] map, input logic r, f, input logic [3:0] p,
                         input logic [1:0] s, input logic sr, rbs, pe, input logic [7:0] exp);
        reg_wr(SPACE_MAP_OFS, map);
        acc(1'b0, r, f, 16'h8000, 8'h00, p, s, sr, rbs, pe);
        chk({8'h00, primary_sel_o, secondary_sel_o, sram_en_o, io_sel_o}, {8'h00, exp}, "route");
    endtask : route

    task automatic wait_read();
        int n;
        n = 0;
        while (read_mode_o !== 1'b1 && n < 40) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        chk({15'h0, read_mode_o}, 16'h1, "read mode");
        if (read_mode_o !== 1'b1) tally_and_finish();
    endtask : wait_read

    task automatic t_regs();
        reg_rd(SPACE_MAP_OFS, 8'h0C, "map init");
        reg_rd(PRIM_PROT_OFS, 8'h00, "prot");
        reg_rd(8'h10, 8'h00, "unmapped");
        reg_wr(PAGE_OFS, 8'h5A);
        chk({8'h00, page_bits_o}, 16'h5A, "page bits");
        reg_rd(PAGE_OFS, 8'h5A, "page");
        @(posedge ref_clk_i);
        {rb, wr, addr, wdata} <= {1'b1, 1'b1, 8'h00, PAGE_OFS, 8'h66};
        @(posedge ref_clk_i);
        {wr, rd} <= 2'b01;
        @(posedge ref_clk_i);
        {rb, rd} <= 2'b00;
        #1;
        chk({8'h00, rdata_o}, 16'h0066, "page back to back");
        reg_wr(PAGE_OFS, 8'hA5);
        reg_rd(PAGE_OFS, 8'hA5, "page");
        reg_wr(SPACE_MAP_OFS, 8'hFF);
        reg_rd(SPACE_MAP_OFS, 8'h9F, "map unused");
        reg_wr(PRIM_PROT_OFS, 8'hFF);
        reg_rd(PRIM_PROT_OFS, 8'h00, "prot write");
    endtask : t_regs

    task automatic t_routes();
        route(8'h18, 1, 0, 4'h1, 2'h1, 0, 0, 0, 8'h04);
        route(8'h10, 1, 0, 4'h2, 2'h1, 0, 0, 0, 8'h20);
        route(8'h10, 1, 0, 4'h1, 2'h0, 1, 0, 0, 8'h02);
        route(8'h10, 1, 0, 4'h1, 2'h0, 0, 1, 0, 8'h01);
        route(8'h0C, 0, 1, 4'h4, 2'h0, 0, 0, 0, 8'h40);
        route(8'h0C, 1, 0, 4'h4, 2'h0, 0, 0, 0, 8'h00);
        route(8'h0C, 1, 0, 4'h0, 2'h2, 0, 0, 0, 8'h08);
        route(8'h14, 1, 0, 4'h8, 2'h0, 0, 0, 0, 8'h80);
        route(8'h14, 0, 1, 4'h8, 2'h0, 0, 0, 0, 8'h80);
        route(8'h10, 0, 1, 4'h1, 2'h0, 0, 0, 0, 8'h00);
        route(8'h02, 0, 1, 4'h0, 2'h1, 0, 0, 0, 8'h04);
        route(8'h01, 0, 1, 4'h0, 2'h0, 1, 0, 0, 8'h02);
        route(8'h00, 0, 1, 4'h0, 2'h0, 1, 0, 0, 8'h00);
        route(8'h80, 1, 0, 4'h0, 2'h0, 0, 0, 1, 8'h01);
        route(8'h00, 1, 0, 4'h0, 2'h0, 0, 0, 1, 8'h00);
        reg_wr(SPACE_MAP_OFS, 8'h0C);
    endtask : t_routes

    task automatic t_reset_cmd();
        status(5'b00001);
        cmd(16'h0555, 8'hAA, 4'h1, 2'h0);
        cmd(16'h0AAA, 8'h55, 4'h1, 2'h0);
        cmd(16'h0000, 8'hF0, 4'h1, 2'h0);
        chk({15'h0, reset_flash_o}, 16'h1, "reset pulse");
        chk({15'h0, read_mode_o}, 16'h0, "read mode busy");
        repeat (RW - 3) @(posedge ref_clk_i);
        #1;
        chk({15'h0, read_mode_o}, 16'h0, "read mode wait");
        wait_read();
        status(5'b00100);
        cmd(16'h0000, 8'hF0, 4'h1, 2'h0);
        chk({14'h0, reset_flash_o, abort_erase_o}, 16'h3, "abort");
        wait_read();
        status(5'b10000);
        cmd(16'h0000, 8'hF0, 4'h1, 2'h0);
        chk({15'h0, reset_flash_o}, 16'h0, "reset in program");
        status(5'b01000);
        cmd(16'h0000, 8'hF0, 4'h1, 2'h0);
        chk({15'h0, reset_flash_o}, 16'h0, "reset in bulk");
    endtask : t_reset_cmd

    task automatic t_resume();
        status(5'b00010);
        cmd(16'h8100, 8'h12, 4'h1, 2'h0);
        chk({15'h0, flash_wr_o}, 16'h0, "write suspended");
        cmd(16'h8100, 8'h30, 4'h1, 2'h0);
        chk({15'h0, resume_erase_o}, 16'h1, "resume");
        status(5'b00000);
        cmd(16'h8100, 8'h30, 4'h1, 2'h0);
        chk({15'h0, resume_erase_o}, 16'h0, "resume idle");
    endtask : t_resume

    task automatic t_protect();
        @(posedge ref_clk_i);
        {ld, prot_p, prot_s, sec} <= {1'b1, 4'hA, 2'h1, 1'b1};
        @(posedge ref_clk_i);
        ld <= 1'b0;
        reg_rd(PRIM_PROT_OFS, 8'h0A, "primary prot");
        reg_rd(SEC_PROT_OFS, 8'h81, "secondary prot");
        reg_wr(SEC_PROT_OFS, 8'h00);
        reg_rd(SEC_PROT_OFS, 8'h81, "prot write");
        cmd(16'h0000, CMD_RESET, 4'h1, 2'h0);
        chk({14'h0, reset_flash_o, read_mode_o}, 16'h3, "reset after status");
        cmd(16'h8123, 8'h12, 4'h2, 2'h0);
        chk({15'h0, flash_wr_o}, 16'h0, "protected write");
        cmd(16'h8124, 8'h34, 4'h1, 2'h0);
        chk({7'h0, flash_wr_o, flash_wdata_o}, 16'h0134, "open write");
        chk(flash_waddr_o, 16'h8124, "write addr");
        cmd(16'h8125, 8'h56, 4'h1, 2'h1);
        chk({15'h0, flash_wr_o}, 16'h0, "secondary protected");
        route(8'h18, 1, 0, 4'h2, 2'h0, 0, 0, 0, 8'h20);
    endtask : t_protect

    initial begin
        {rst_n_i, wr, rd, fetch, sram, rb, per, ld, sec, set} = '0;
        {addr, wdata, psel, ssel, prot_p, prot_s, st_set} = '0;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_routes();
        t_reset_cmd();
        t_resume();
        t_protect();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : flash_sram_select_and_paging_bench

// [fssp_byte_reg.sv]
`timescale 1ns/1ps
module fssp_byte_reg
    import fssp_pkg::*;
#(
    parameter int         W    = 8,
    parameter logic [7:0] RST  = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  ce_i,
    fssp_reg_if.owner  r
);
    if (W < 1 || W > 8) begin : g_bad_width
        $error("fssp_byte_reg width must be 1 to 8");
    end

    // unused bits are masked on load so they always read zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r.q <= RST[W-1:0] & MASK[W-1:0];
        end else if (ce_i && r.we) begin
            r.q <= r.wd & MASK[W-1:0];
        end
    end
endmodule : fssp_byte_reg

// [fssp_flash_model.sv]
`timescale 1ns/1ps
module fssp_flash_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       set_i,
    input  wire logic [4:0] st_i,
    input  wire logic       reset_flash_i,
    input  wire logic       abort_erase_i,
    input  wire logic       resume_erase_i,
    output logic [4:0]      st_o
);
    // status bits: program, bulk erase, sector erase, suspended, error
    // bench loads a state directly; engine reacts to command pulses only
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_o <= 5'h00;
        end else if (set_i) begin
            st_o <= st_i;
        end else if (resume_erase_i) begin
            st_o[2:1] <= 2'b10;
        end else if (abort_erase_i) begin
            st_o[2:0] <= 3'b000;
        end else if (reset_flash_i) begin
            st_o[1:0] <= 2'b00;
        end
    end
endmodule : fssp_flash_model

// [fssp_mem_ctrl.sv]
`timescale 1ns/1ps
module fssp_mem_ctrl
    import fssp_pkg::*;
#(
    parameter int         RESET_WAIT     = RESET_WAIT_CYC,
    parameter logic [7:0] SPACE_MAP_INIT = SPACE_MAP_RST
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        program_fetch_strobe_i,
    input  wire logic [3:0]  primary_sector_selects_i,
    input  wire logic [1:0]  secondary_sector_selects_i,
    input  wire logic        sram_select_i,
    input  wire logic        register_block_select_i,
    input  wire logic        periph_select_i,
    input  wire logic        prot_load_i,
    input  wire logic [3:0]  prot_primary_i,
    input  wire logic [1:0]  prot_secondary_i,
    input  wire logic        security_set_i,
    input  wire logic        prog_busy_i,
    input  wire logic        bulk_erase_busy_i,
    input  wire logic        sector_erase_busy_i,
    input  wire logic        erase_suspended_i,
    input  wire logic        error_flag_i,
    output logic [3:0]       primary_sel_o,
    output logic [1:0]       secondary_sel_o,
    output logic             sram_en_o,
    output logic             io_sel_o,
    output logic [7:0]       rdata_o,
    output logic [7:0]       page_bits_o,
    output logic             flash_wr_o,
    output logic [7:0]       flash_wdata_o,
    output logic [15:0]      flash_waddr_o,
    output logic             resume_erase_o,
    output logic             reset_flash_o,
    output logic             abort_erase_o,
    output logic             read_mode_o
);
    if (RESET_WAIT < 1) begin : g_bad_wait
        $error("RESET_WAIT must be at least one cycle");
    end

    fssp_reg_if #(.W(8)) page_if ();
    fssp_reg_if #(.W(8)) map_if ();
    fssp_reg_if #(.W(8)) pprot_if ();
    fssp_reg_if #(.W(8)) sprot_if ();

    fssp_unlock_e unl_r;
    fssp_unlock_e unl_nxt;

    logic [3:0]  primary_sel_r;
    logic [1:0]  secondary_sel_r;
    logic        sram_en_r;
    logic        io_sel_r;
    logic [7:0]  rdata_r;
    logic        flash_wr_r;
    logic [7:0]  flash_wdata_r;
    logic [15:0] flash_waddr_r;
    logic        resume_r;
    logic        reset_flash_r;
    logic        abort_r;
    logic        read_mode_r;
    logic        tmr_busy;

    wire [7:0] ofs      = addr_i[7:0];
    wire [7:0] map      = map_if.q;
    wire       reg_wr   = register_block_select_i & wr_i;
    wire       io_hit   = register_block_select_i
                        | (periph_select_i & map[MAP_PERIPH_IO]);
    wire       prim_any = |primary_sector_selects_i;
    wire       sec_any  = |secondary_sector_selects_i;

    // register file: protection only loads from the test port
    assign page_if.we  = reg_wr & (ofs == PAGE_OFS);
    assign page_if.wd  = wdata_i;
    assign map_if.we   = reg_wr & (ofs == SPACE_MAP_OFS);
    assign map_if.wd   = wdata_i;
    assign pprot_if.we = prot_load_i;
    assign pprot_if.wd = {4'h0, prot_primary_i};
    assign sprot_if.we = prot_load_i;
    assign sprot_if.wd = {security_set_i, 5'h00, prot_secondary_i};

    fssp_byte_reg #(.W(8), .RST(PAGE_RST), .MASK(PAGE_MASK)) u_page (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .r         (page_if.owner)
    );
    fssp_byte_reg #(.W(8), .RST(SPACE_MAP_INIT), .MASK(SPACE_MAP_MASK)) u_map (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .r         (map_if.owner)
    );
    fssp_byte_reg #(.W(8), .RST(PROT_RST), .MASK(PRIM_PROT_MASK)) u_pprot (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .r         (pprot_if.owner)
    );
    fssp_byte_reg #(.W(8), .RST(PROT_RST), .MASK(SEC_PROT_MASK)) u_sprot (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .r         (sprot_if.owner)
    );

    // read mux, unmapped offsets read zero
    wire [7:0] rdata_nxt = (!(register_block_select_i & rd_i)) ? rdata_r :
                           (ofs == PAGE_OFS)      ? page_if.q  :
                           (ofs == SPACE_MAP_OFS) ? map        :
                           (ofs == PRIM_PROT_OFS) ? pprot_if.q :
                           (ofs == SEC_PROT_OFS)  ? sprot_if.q :
                           8'h00;

    // memory routing: strobe gating first, then fixed priority
    wire sram_ok = sram_select_i
                 & (rd_i | wr_i | (program_fetch_strobe_i & map[MAP_SRAM_CODE]));
    wire io_ok   = io_hit & (rd_i | wr_i);
    wire prim_ok = prim_any & ((rd_i & map[MAP_PRIM_DATA])
                 | (program_fetch_strobe_i & map[MAP_PRIM_CODE]));
    wire sec_ok  = sec_any & ((rd_i & map[MAP_SEC_DATA])
                 | (program_fetch_strobe_i & map[MAP_SEC_CODE]));

    wire       io_nxt   = io_ok;
    wire       sram_nxt = sram_ok & ~io_ok;
    wire       sec_win  = sec_ok & ~io_ok & ~sram_ok;
    wire       prim_win = prim_ok & ~io_ok & ~sram_ok & ~sec_ok;
    wire [1:0] sec_nxt  = sec_win ? secondary_sector_selects_i : 2'b00;
    wire [3:0] prim_nxt = prim_win ? primary_sector_selects_i : 4'h0;
    // reads are never gated by protection, so verify sees stored data

    // flash write path
    wire flash_hit = wr_i & ~io_hit & ~sram_select_i & (prim_any | sec_any);
    wire tgt_prot  = sec_any
                   ? |(secondary_sector_selects_i & sprot_if.q[1:0])
                   : |(primary_sector_selects_i & pprot_if.q[3:0]);
    wire is_resume = flash_hit & (wdata_i == CMD_RESUME);
    wire is_reset  = flash_hit & (wdata_i == CMD_RESET);
    wire resume_go = is_resume & erase_suspended_i;
    wire flash_busy_hard = prog_busy_i | bulk_erase_busy_i;
    wire reset_go  = is_reset & ~flash_busy_hard;
    wire abort_nxt = reset_go & sector_erase_busy_i;
    wire tmr_start = reset_go & (error_flag_i | sector_erase_busy_i);
    // suspension refuses every write except resume and reset, including program data
    wire fwd_wr    = flash_hit & ~is_resume & ~is_reset
                   & ~erase_suspended_i & ~tgt_prot;
    wire read_mode_nxt = ~(tmr_start | tmr_busy | flash_busy_hard | sector_erase_busy_i);

    // unlock tracking: the reset write counts with or without the prefix
    wire unl1_hit = flash_hit & (addr_i[11:0] == UNLOCK1_ADDR) & (wdata_i == UNLOCK1_DATA);
    wire unl2_hit = flash_hit & (addr_i[11:0] == UNLOCK2_ADDR) & (wdata_i == UNLOCK2_DATA);

    always_comb begin
        unl_nxt = unl_r;
        if (flash_hit) begin
            case (unl_r)
                UNL_IDLE:   unl_nxt = unl1_hit ? UNL_FIRST : UNL_IDLE;
                UNL_FIRST:  unl_nxt = unl2_hit ? UNL_SECOND : UNL_IDLE;
                UNL_SECOND: unl_nxt = UNL_IDLE;
                default:    unl_nxt = UNL_IDLE;
            endcase
        end
    end

    fssp_reset_timer #(.CYC(RESET_WAIT)) u_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .start_i   (tmr_start),
        .busy_o    (tmr_busy)
    );

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            unl_r <= UNL_IDLE;
        end else if (ce_i) begin
            unl_r <= unl_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            primary_sel_r   <= 4'h0;
            secondary_sel_r <= 2'b00;
            sram_en_r       <= 1'b0;
            io_sel_r        <= 1'b0;
            rdata_r         <= 8'h00;
        end else if (ce_i) begin
            primary_sel_r   <= prim_nxt;
            secondary_sel_r <= sec_nxt;
            sram_en_r       <= sram_nxt;
            io_sel_r        <= io_nxt;
            rdata_r         <= rdata_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flash_wr_r    <= 1'b0;
            flash_wdata_r <= 8'h00;
            flash_waddr_r <= 16'h0000;
            resume_r      <= 1'b0;
            reset_flash_r <= 1'b0;
            abort_r       <= 1'b0;
            read_mode_r   <= 1'b1;
        end else if (ce_i) begin
            flash_wr_r    <= fwd_wr;
            flash_wdata_r <= fwd_wr ? wdata_i : flash_wdata_r;
            flash_waddr_r <= fwd_wr ? addr_i : flash_waddr_r;
            resume_r      <= resume_go;
            reset_flash_r <= reset_go;
            abort_r       <= abort_nxt;
            read_mode_r   <= read_mode_nxt;
        end
    end

    assign primary_sel_o   = primary_sel_r;
    assign secondary_sel_o = secondary_sel_r;
    assign sram_en_o       = sram_en_r;
    assign io_sel_o        = io_sel_r;
    assign rdata_o         = rdata_r;
    assign page_bits_o     = page_if.q;
    assign flash_wr_o      = flash_wr_r;
    assign flash_wdata_o   = flash_wdata_r;
    assign flash_waddr_o   = flash_waddr_r;
    assign resume_erase_o  = resume_r;
    assign reset_flash_o   = reset_flash_r;
    assign abort_erase_o   = abort_r;
    assign read_mode_o     = read_mode_r;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_resume_cmd_pulse: assert property (ce_i && resume_go |=> resume_erase_o)
        else $error("resume not issued");
    a_suspend_no_prog: assert property (ce_i && erase_suspended_i |=> !flash_wr_o)
        else $error("write forwarded while suspended");
    a_protect_drop_wr: assert property (ce_i && flash_hit && tgt_prot
        |=> !flash_wr_o)
        else $error("write reached protected sector");
    a_prot_mcu_ro: assert property (ce_i && reg_wr && !prot_load_i
        |=> $stable(pprot_if.q) && $stable(sprot_if.q))
        else $error("mcu write changed protection");
    a_reset_busy_ign: assert property (ce_i && is_reset && flash_busy_hard
        |=> !reset_flash_o)
        else $error("reset accepted while busy");
    a_reset_abort_wait: assert property (ce_i && reset_go && sector_erase_busy_i
        |=> abort_erase_o && !read_mode_o ##1 (!read_mode_o || !ce_i))
        else $error("sector erase abort wrong");
    a_sec_over_prim: assert property (ce_i && sec_ok && prim_ok && !sram_ok && !io_ok
        |=> secondary_sel_o != 2'b00 && primary_sel_o == 4'h0)
        else $error("primary won over secondary");
    a_io_over_flash: assert property (ce_i && io_ok
        |=> io_sel_o && !sram_en_o && primary_sel_o == 4'h0 && secondary_sel_o == 2'b00)
        else $error("flash won over io");
    a_sram_needs_sel: assert property (ce_i && !sram_select_i |=> !sram_en_o)
        else $error("sram enabled without select");
    a_map_fetch_gate: assert property (ce_i && program_fetch_strobe_i && !rd_i
        && !map[MAP_PRIM_CODE] |=> primary_sel_o == 4'h0)
        else $error("fetch reached primary flash while gated");
    a_page_readback: assert property (ce_i && page_if.we ##1 ce_i
        && register_block_select_i && rd_i && ofs == PAGE_OFS && !page_if.we
        |=> rdata_o == $past(wdata_i, 2))
        else $error("page readback mismatch");

    // routing and gating, one cycle after the strobe
    a_sram_over_flash: assert property (ce_i && sram_ok && !io_ok
        |=> sram_en_o && primary_sel_o == 4'h0 && secondary_sel_o == 2'b00)
        else $error("flash won over sram");
    a_sram_fetch_gate: assert property (ce_i && program_fetch_strobe_i && !rd_i
        && !wr_i && !map[MAP_SRAM_CODE] |=> !sram_en_o)
        else $error("fetch reached sram while gated");
    a_sec_fetch_gate: assert property (ce_i && program_fetch_strobe_i && !rd_i
        && !map[MAP_SEC_CODE] |=> secondary_sel_o == 2'b00)
        else $error("fetch reached secondary while gated");
    a_read_prim_gate: assert property (ce_i && rd_i && !program_fetch_strobe_i
        && !map[MAP_PRIM_DATA] |=> primary_sel_o == 4'h0)
        else $error("read reached primary while gated");
    a_combined_prim: assert property (ce_i && map[MAP_PRIM_CODE]
        && map[MAP_PRIM_DATA] && (rd_i || program_fetch_strobe_i) && prim_any
        && !sec_ok && !sram_ok && !io_ok |=> primary_sel_o == $past(primary_sector_selects_i))
        else $error("primary missing in combined space");
    // flash commands and protection
    a_reset_accept: assert property (ce_i && is_reset && !flash_busy_hard
        |=> reset_flash_o)
        else $error("reset instruction lost");
    a_resume_refused: assert property (ce_i && is_resume && !erase_suspended_i
        |=> !resume_erase_o)
        else $error("resume issued while not suspended");
    a_error_wait: assert property (ce_i && reset_go && error_flag_i
        |=> reset_flash_o && !read_mode_o)
        else $error("read mode before error wait");
    a_fwd_write: assert property (ce_i && fwd_wr |=> flash_wr_o
        && flash_wdata_o == $past(wdata_i) && flash_waddr_o == $past(addr_i))
        else $error("forwarded write wrong");
    a_cmd_not_data: assert property (ce_i && (is_resume || is_reset)
        |=> !flash_wr_o)
        else $error("instruction forwarded as data");
    a_prim_prot_load: assert property (ce_i && prot_load_i
        |=> pprot_if.q == {4'h0, $past(prot_primary_i)})
        else $error("primary protection status wrong");
    a_sec_prot_load: assert property (ce_i && prot_load_i
        |=> sprot_if.q[SEC_SECURE_BIT] == $past(security_set_i)
        && sprot_if.q[1:0] == $past(prot_secondary_i))
        else $error("secondary protection status wrong");
    a_unused_zero: assert property (map[6:5] == 2'b00 && pprot_if.q[7:4] == 4'h0
        && sprot_if.q[6:2] == 5'h00)
        else $error("unused register bit set");

    c_resume: cover property (ce_i && resume_go);
    c_reset_unlocked: cover property (ce_i && reset_go && unl_r == UNL_SECOND);
    c_sec_overlap: cover property (ce_i && sec_win && prim_any);
    c_map_rewrite: cover property (ce_i && map_if.we);
endmodule : fssp_mem_ctrl

// [fssp_pkg.sv]
package fssp_pkg;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          RESET_WAIT_MS  = 2;
    localparam int          RESET_WAIT_CYC = RESET_WAIT_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [7:0]  PAGE_OFS       = 8'hE0;
    localparam logic [7:0]  PRIM_PROT_OFS  = 8'hC0;
    localparam logic [7:0]  SEC_PROT_OFS   = 8'hC2;
    localparam logic [7:0]  SPACE_MAP_OFS  = 8'hB0;

    localparam int          MAP_PERIPH_IO  = 7;
    localparam int          MAP_PRIM_DATA  = 4;
    localparam int          MAP_SEC_DATA   = 3;
    localparam int          MAP_PRIM_CODE  = 2;
    localparam int          MAP_SEC_CODE   = 1;
    localparam int          MAP_SRAM_CODE  = 0;
    localparam int          SEC_SECURE_BIT = 7;

    localparam logic [7:0]  SPACE_MAP_MASK = 8'h9F;
    localparam logic [7:0]  PRIM_PROT_MASK = 8'h0F;
    localparam logic [7:0]  SEC_PROT_MASK  = 8'h83;
    localparam logic [7:0]  PAGE_MASK      = 8'hFF;

    localparam logic [7:0]  SPACE_MAP_RST  = 8'h0C;
    localparam logic [7:0]  PAGE_RST       = 8'h00;
    localparam logic [7:0]  PROT_RST       = 8'h00;

    localparam logic [7:0]  CMD_RESUME     = 8'h30;
    localparam logic [7:0]  CMD_RESET      = 8'hF0;
    localparam logic [7:0]  UNLOCK1_DATA   = 8'hAA;
    localparam logic [11:0] UNLOCK1_ADDR   = 12'h555;
    localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
    localparam logic [11:0] UNLOCK2_ADDR   = 12'hAAA;

    typedef enum logic [1:0] {
        UNL_IDLE   = 2'b00,
        UNL_FIRST  = 2'b01,
        UNL_SECOND = 2'b11
    } fssp_unlock_e;
endpackage : fssp_pkg

// [fssp_reg_if.sv]
`timescale 1ns/1ps
interface fssp_reg_if #(parameter int W = 8);
    logic         we;
    logic [W-1:0] wd;
    logic [W-1:0] q;
    modport owner (input we, input wd, output q);
    modport user  (output we, output wd, input q);
endinterface : fssp_reg_if

// [fssp_reset_timer.sv]
`timescale 1ns/1ps
module fssp_reset_timer #(
    parameter int CYC = 200000
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    output logic      busy_o
);
    localparam int             CW   = $clog2(CYC + 1);
    localparam logic [CW-1:0]  LOAD = CW'(CYC);

    if (CYC < 1) begin : g_bad_cyc
        $error("fssp_reset_timer needs at least one cycle");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    assign cnt_nxt = start_i ? LOAD : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
    assign busy_o  = (cnt_r != '0);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : fssp_reset_timer
